//--- src/urx_pkg.sv
`default_nettype none
package urx_pkg;
    // Register bus geometry
    localparam int         URX_AXI_AW   = 8;
    localparam int         URX_AXI_DW   = 32;
    localparam int         URX_BAUD_W   = 12;

    // Register byte offsets
    localparam logic [7:0] URX_OFF_MODE = 8'h00;
    localparam logic [7:0] URX_OFF_FMT  = 8'h04;
    localparam logic [7:0] URX_OFF_CTRL = 8'h08;
    localparam logic [7:0] URX_OFF_BUF  = 8'h0C;
    localparam logic [7:0] URX_OFF_STAT = 8'h10;
    localparam logic [7:0] URX_OFF_BRL  = 8'h14;
    localparam logic [7:0] URX_OFF_BRH  = 8'h18;

    // mode_reg_zero fields
    localparam int         URX_MODE_DIR = 0;
    localparam int         URX_MODE_PIN = 1;
    localparam int         URX_MODE_CKLO = 2;
    localparam int         URX_MODE_CKHI = 3;
    localparam int         URX_MODE_RSS = 4;
    localparam logic [7:0] URX_MODE_MASK = 8'h1F;
    localparam logic [7:0] URX_MODE_RST = 8'h00;

    // frame_format_reg fields
    localparam int         URX_FMT_LEN  = 0;
    localparam int         URX_FMT_PEN  = 2;
    localparam int         URX_FMT_ODD  = 3;
    localparam int         URX_FMT_STP2 = 4;
    localparam int         URX_FMT_MSB  = 5;
    localparam int         URX_FMT_NEG  = 6;
    localparam logic [7:0] URX_FMT_MASK = 8'h7F;
    localparam logic [7:0] URX_FMT_RST  = 8'h00;

    // control_reg and status_reg fields
    localparam int         URX_CTRL_RUN = 0;
    localparam int         URX_STAT_FER = 0;
    localparam int         URX_STAT_OER = 1;
    localparam int         URX_STAT_PER = 2;

    // Baud count reset values
    localparam logic [7:0] URX_BRL_RST  = 8'h00;
    localparam logic [3:0] URX_BRH_RST  = 4'h0;

    // AXI response codes
    localparam logic [1:0] URX_RESP_OKAY = 2'h0;
    localparam logic [1:0] URX_RESP_SLVERR = 2'h2;

    // Receive sequencer states
    typedef enum logic [2:0] {
        URX_IDLE  = 3'b000,
        URX_START = 3'b001,
        URX_DATA  = 3'b010,
        URX_PAR   = 3'b011,
        URX_LOAD  = 3'b100,
        URX_STOP1 = 3'b101,
        URX_STOP2 = 3'b110
    } urx_state_t;
endpackage
`default_nettype wire

//--- src/urx_bitgen.sv
`timescale 1ns/1ps
`default_nettype none
module urx_bitgen
    import urx_pkg::*;
#(
    parameter int CNT_W = URX_BAUD_W
) (
    input  wire logic             core_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             tick_i,
    input  wire logic             start_i,
    input  wire logic             run_i,
    input  wire logic [CNT_W-1:0] count_i,
    input  wire logic             shift_i,
    output logic                  rise_o,
    output logic                  fall_o
);
    logic             running_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W:0]   half;
    logic [CNT_W:0]   mid;

    // Mid-bit point, optionally one source tick late
    assign half   = ({1'b0, count_i} + {{CNT_W{1'b0}}, 1'b1}) >> 1;
    assign mid    = half + {{CNT_W{1'b0}}, shift_i};
    assign rise_o = running_r && run_i && tick_i && ({1'b0, cnt_r} == mid);
    assign fall_o = running_r && run_i && tick_i && (cnt_r == count_i);

    // Detection tick is tick zero of the start bit, so counting resumes at one; else every sample lands a tick late
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            running_r <= 1'b0;
            cnt_r     <= '0;
        end else if (start_i) begin
            running_r <= 1'b1;
            cnt_r     <= {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (!run_i) begin
            running_r <= 1'b0;
        end else if (tick_i && running_r) begin
            cnt_r <= (cnt_r == count_i) ? '0 : cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    bit_wrap_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (fall_o && !start_i) |=> (cnt_r == '0))
        else $error("bit counter did not wrap at bit end");
endmodule
`default_nettype wire

//--- src/urx_receiver.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module urx_receiver
    import urx_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic [URX_AXI_AW-1:0] s_axi_awaddr_i,
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [URX_AXI_DW-1:0] s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    output logic [1:0]                 s_axi_bresp_o,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    input  wire logic [URX_AXI_AW-1:0] s_axi_araddr_i,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    output logic [URX_AXI_DW-1:0]      s_axi_rdata_o,
    output logic [1:0]                 s_axi_rresp_o,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i,
    input  wire logic                  low_speed_clock_i,
    input  wire logic                  high_speed_clock_i,
    input  wire logic                  serial_rx_input_0_i,
    input  wire logic                  serial_rx_input_1_i,
    output logic                       port_interrupt_o
);
    // Word-aligned address match, shared by read and write decode
    function automatic logic reg_hit(input logic [URX_AXI_AW-1:0] a, input logic [7:0] off);
        return a[URX_AXI_AW-1:2] == off[URX_AXI_AW-1:2];
    endfunction

    logic [7:0]            mode_r;
    logic [7:0]            fmt_r;
    logic                  run_r;
    logic                  run_prev_r;
    logic [7:0]            brl_r;
    logic [3:0]            brh_r;
    logic [7:0]            buf_r;
    logic                  unread_r;
    logic                  fer_r;
    logic                  oer_r;
    logic                  per_r;
    logic                  irq_r;
    logic [1:0]            rx_meta_r;
    logic [1:0]            rx_sync_r;
    urx_state_t            state_r;
    logic [2:0]            idx_r;
    logic [7:0]            data_r;
    logic                  par_acc_r;
    logic                  par_bit_r;
    logic                  start_bad_r;
    logic                  aw_held_r;
    logic                  w_held_r;
    logic                  awready_r;
    logic                  wready_r;
    logic [URX_AXI_AW-1:0] awaddr_r;
    logic [7:0]            wdata_r;
    logic                  wstrb0_r;
    logic                  bvalid_r;
    logic [1:0]            bresp_r;
    logic                  arready_r;
    logic                  rvalid_r;
    logic [31:0]           rdata_r;
    logic [1:0]            rresp_r;
    logic                  wr_do;
    logic                  rd_take;
    logic                  rd_buf;
    logic [31:0]           rd_mux;
    logic [1:0]            rd_resp;
    logic                  rx_active;
    logic                  line;
    logic                  src_tick;
    logic                  start_go;
    logic                  bg_rise;
    logic                  bg_fall;
    logic                  load_go;
    logic                  stop_eval;
    logic                  stat_wr;
    logic [3:0]            nbits;
    logic [2:0]            nlast;
    logic [2:0]            pos;

    // Two-stage synchronisers on both receive pins; only the second stage is read
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rx_meta_r <= 2'h3;
            rx_sync_r <= 2'h3;
        end else begin
            rx_meta_r <= {serial_rx_input_1_i, serial_rx_input_0_i};
            rx_sync_r <= rx_meta_r;
        end
    end

    // Line after pin choice and polarity, so a start bit always reads low
    assign line      = (mode_r[URX_MODE_PIN] ? rx_sync_r[1] : rx_sync_r[0]) ^ fmt_r[URX_FMT_NEG];
    assign rx_active = run_r && mode_r[URX_MODE_DIR];

    // Baud source select; codes 1x fall back to the high-speed tick
    always_comb begin
        case ({mode_r[URX_MODE_CKHI], mode_r[URX_MODE_CKLO]})
            2'b00:   src_tick = low_speed_clock_i;
            default: src_tick = high_speed_clock_i;
        endcase
    end

    // Start detection only on a source tick, hence up to one tick of lag
    assign start_go  = rx_active && (state_r == URX_IDLE) && src_tick && !line;
    assign load_go   = rx_active && (state_r == URX_LOAD) && bg_fall;
    assign stop_eval = rx_active && (state_r == URX_STOP1) && bg_rise;
    assign nbits     = 4'h8 - {2'h0, fmt_r[URX_FMT_LEN +: 2]};
    assign nlast     = 3'(nbits - 4'h1);
    assign pos       = fmt_r[URX_FMT_MSB] ? (nlast - idx_r) : idx_r;

    urx_bitgen #(
        .CNT_W (URX_BAUD_W)
    ) u_bitgen (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .tick_i     (src_tick),
        .start_i    (start_go),
        .run_i      (rx_active && (state_r != URX_IDLE)),
        .count_i    ({brh_r, brl_r}),
        .shift_i    (mode_r[URX_MODE_RSS]),
        .rise_o     (bg_rise),
        .fall_o     (bg_fall)
    );

    // Receive sequencer; dropping enable or direction aborts to idle at once
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_r     <= URX_IDLE;
            idx_r       <= 3'h0;
            data_r      <= 8'h00;
            par_acc_r   <= 1'b0;
            par_bit_r   <= 1'b0;
            start_bad_r <= 1'b0;
        end else if (!rx_active) begin
            state_r <= URX_IDLE;
        end else begin
            case (state_r)
                URX_IDLE: begin
                    if (start_go) begin
                        state_r <= URX_START;
                    end
                end
                URX_START: begin
                    if (bg_rise) begin
                        start_bad_r <= line;
                        idx_r       <= 3'h0;
                        data_r      <= 8'h00;
                        par_acc_r   <= 1'b0;
                        state_r     <= URX_DATA;
                    end
                end
                URX_DATA: begin
                    if (bg_rise) begin
                        data_r[pos] <= line;
                        par_acc_r   <= par_acc_r ^ line;
                        idx_r       <= idx_r + 3'h1;
                        if (idx_r == nlast) begin
                            state_r <= fmt_r[URX_FMT_PEN] ? URX_PAR : URX_LOAD;
                        end
                    end
                end
                URX_PAR: begin
                    if (bg_rise) begin
                        par_bit_r <= line;
                        state_r   <= URX_LOAD;
                    end
                end
                URX_LOAD: begin
                    if (bg_fall) begin
                        state_r <= URX_STOP1;
                    end
                end
                URX_STOP1: begin
                    if (bg_rise) begin
                        state_r <= fmt_r[URX_FMT_STP2] ? URX_STOP2 : URX_IDLE;
                    end
                end
                URX_STOP2: begin
                    if (bg_rise) begin
                        state_r <= URX_IDLE;
                    end
                end
                default: state_r <= URX_IDLE;
            endcase
        end
    end

    // Buffer load and unread tracking; a load in the read cycle keeps the word unread
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            buf_r    <= 8'h00;
            unread_r <= 1'b0;
        end else if (load_go) begin
            buf_r    <= data_r;
            unread_r <= 1'b1;
        end else if (rd_buf) begin
            unread_r <= 1'b0;
        end
    end

    // Error flags: events beat software clears; all forced low in transmit direction
    assign stat_wr = wr_do && wstrb0_r && reg_hit(awaddr_r, URX_OFF_STAT);
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || !mode_r[URX_MODE_DIR]) begin
            fer_r <= 1'b0;
            oer_r <= 1'b0;
            per_r <= 1'b0;
        end else begin
            if (stop_eval) begin
                fer_r <= start_bad_r || !line;
            end else if (rx_active && (state_r == URX_STOP2) && bg_rise && !line) begin
                fer_r <= 1'b1;
            end else if (stat_wr && wdata_r[URX_STAT_FER]) begin
                fer_r <= 1'b0;
            end
            if (stop_eval) begin
                per_r <= fmt_r[URX_FMT_PEN] && (par_acc_r ^ par_bit_r ^ fmt_r[URX_FMT_ODD]);
            end else if (stat_wr && wdata_r[URX_STAT_PER]) begin
                per_r <= 1'b0;
            end
            if ((load_go || (run_r && !run_prev_r)) && unread_r) begin
                oer_r <= 1'b1;
            end else if (stat_wr && wdata_r[URX_STAT_OER]) begin
                oer_r <= 1'b0;
            end
        end
    end

    // Interrupt pulse on the rising edge after the word was fetched
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= stop_eval;
        end
    end

    // Software-written configuration; reserved bits are never stored
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            mode_r     <= URX_MODE_RST;
            fmt_r      <= URX_FMT_RST;
            run_r      <= 1'b0;
            run_prev_r <= 1'b0;
            brl_r      <= URX_BRL_RST;
            brh_r      <= URX_BRH_RST;
        end else begin
            run_prev_r <= run_r;
            if (wr_do && wstrb0_r) begin
                if (reg_hit(awaddr_r, URX_OFF_MODE)) begin
                    mode_r <= wdata_r & URX_MODE_MASK;
                end
                if (reg_hit(awaddr_r, URX_OFF_FMT)) begin
                    fmt_r <= wdata_r & URX_FMT_MASK;
                end
                if (reg_hit(awaddr_r, URX_OFF_CTRL)) begin
                    run_r <= wdata_r[URX_CTRL_RUN];
                end
                if (reg_hit(awaddr_r, URX_OFF_BRL)) begin
                    brl_r <= wdata_r;
                end
                if (reg_hit(awaddr_r, URX_OFF_BRH)) begin
                    brh_r <= wdata_r[3:0];
                end
            end
        end
    end

    // Write channels: address and data caught independently, answered once both are in
    assign wr_do = aw_held_r && w_held_r && !bvalid_r;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 8'h00;
            wstrb0_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= URX_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && awready_r) begin
                awaddr_r  <= s_axi_awaddr_i;
                aw_held_r <= 1'b1;
                awready_r <= 1'b0;
            end else if (!aw_held_r && !bvalid_r) begin
                awready_r <= 1'b1;
            end
            if (s_axi_wvalid_i && wready_r) begin
                wdata_r  <= s_axi_wdata_i[7:0];
                wstrb0_r <= s_axi_wstrb_i[0];
                w_held_r <= 1'b1;
                wready_r <= 1'b0;
            end else if (!w_held_r && !bvalid_r) begin
                wready_r <= 1'b1;
            end
            if (wr_do) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= (reg_hit(awaddr_r, URX_OFF_BUF) || (awaddr_r > URX_OFF_BRH)) ?
                             URX_RESP_SLVERR : URX_RESP_OKAY;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read data mux; status shows the buffer-full bit as zero in receive use
    always_comb begin
        rd_mux  = 32'h0000_0000;
        rd_resp = URX_RESP_OKAY;
        if (reg_hit(s_axi_araddr_i, URX_OFF_MODE)) begin
            rd_mux[7:0] = mode_r;
        end else if (reg_hit(s_axi_araddr_i, URX_OFF_FMT)) begin
            rd_mux[7:0] = fmt_r;
        end else if (reg_hit(s_axi_araddr_i, URX_OFF_CTRL)) begin
            rd_mux[URX_CTRL_RUN] = run_r;
        end else if (reg_hit(s_axi_araddr_i, URX_OFF_BUF)) begin
            rd_mux[7:0] = buf_r;
        end else if (reg_hit(s_axi_araddr_i, URX_OFF_STAT)) begin
            rd_mux[URX_STAT_FER] = fer_r;
            rd_mux[URX_STAT_OER] = oer_r;
            rd_mux[URX_STAT_PER] = per_r;
        end else if (reg_hit(s_axi_araddr_i, URX_OFF_BRL)) begin
            rd_mux[7:0] = brl_r;
        end else if (reg_hit(s_axi_araddr_i, URX_OFF_BRH)) begin
            rd_mux[3:0] = brh_r;
        end else begin
            rd_resp = URX_RESP_SLVERR;
        end
    end

    // Read channel: one outstanding read, data registered at the address handshake
    assign rd_take = s_axi_arvalid_i && arready_r;
    assign rd_buf  = rd_take && reg_hit(s_axi_araddr_i, URX_OFF_BUF);
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= URX_RESP_OKAY;
        end else if (rd_take) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= rd_resp;
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end else if (!rvalid_r) begin
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o  = wready_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;
    assign port_interrupt_o = irq_r;

    // Checks on the receive sequence
    idle_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (state_r == URX_IDLE && !start_go) |=> (state_r == URX_IDLE))
        else $error("left idle without a start bit");
    start_launch_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        start_go |=> (state_r == URX_START))
        else $error("start bit did not launch frame");
    data_shift_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (rx_active && state_r == URX_DATA && bg_rise) |=> (idx_r == $past(idx_r) + 3'h1))
        else $error("data bit not shifted on rising edge");
    word_load_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        load_go |=> (buf_r == $past(data_r)) && unread_r && (state_r == URX_STOP1))
        else $error("word not loaded on falling edge");
    irq_cause_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        port_interrupt_o |-> $past(state_r) == URX_STOP1 && $past(bg_rise))
        else $error("interrupt outside stop evaluation");
    irq_single_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        port_interrupt_o |=> !port_interrupt_o)
        else $error("interrupt longer than one cycle");
    abort_idle_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !rx_active |=> (state_r == URX_IDLE) && $stable(buf_r))
        else $error("disable did not abort cleanly");
    overrun_set_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (load_go && unread_r && mode_r[URX_MODE_DIR]) |=> oer_r)
        else $error("overwrite did not flag overrun");
    restart_ovr_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (run_r && !run_prev_r && unread_r && mode_r[URX_MODE_DIR]) |=> oer_r)
        else $error("restart with unread word missed overrun");
    tx_zero_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !mode_r[URX_MODE_DIR] |=> !fer_r && !oer_r && !per_r)
        else $error("error flag set in transmit direction");
    parity_eval_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (stop_eval && mode_r[URX_MODE_DIR]) |=>
            per_r == ($past(fmt_r[URX_FMT_PEN]) && ($past(par_acc_r) ^ $past(par_bit_r) ^ $past(fmt_r[URX_FMT_ODD]))))
        else $error("parity flag wrong after frame");
    frame_eval_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (stop_eval && mode_r[URX_MODE_DIR]) |=> fer_r == ($past(start_bad_r) || !$past(line)))
        else $error("framing flag not rewritten");
endmodule
`default_nettype wire

//--- test/urx_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-end transmitter; line rests high between frames like a pulled-up pin
module urx_line_model #(
    parameter int BIT_CYC = 8
) (
    input  wire logic core_clk_i,
    output logic      line_o
);
    initial line_o = 1'b1;
    // One frame, LSB first, 8 data bits; a bad stop value exercises framing
    task automatic send(input logic [7:0] d, input logic pon, pb, sb);
        line_o <= 1'b0;
        repeat (BIT_CYC) @(posedge core_clk_i);
        for (int i = 0; i < 8; i++) begin
            line_o <= d[i];
            repeat (BIT_CYC) @(posedge core_clk_i);
        end
        if (pon) begin
            line_o <= pb;
            repeat (BIT_CYC) @(posedge core_clk_i);
        end
        line_o <= sb;
        repeat (BIT_CYC) @(posedge core_clk_i);
        line_o <= 1'b1;
        repeat (BIT_CYC) @(posedge core_clk_i);
    endtask
endmodule
`default_nettype wire

//--- test/urx_receiver_bench.sv
`timescale 1ns/1ps
`default_nettype none
module urx_receiver_bench;
    import urx_pkg::*;
    logic        core_clk_i = 1'b0, sys_rst_i = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic        awr, wrd, bv, arr, rv, irq, line0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd;
    logic [1:0]  br, rr;
    int          error_cnt = 0, total_checks = 0;
    logic        ls_tick = 1'b0;
    // Clock at 10 MHz
    always #50 core_clk_i = ~core_clk_i;
    // Low-speed source tick: a one-cycle pulse every second clock
    always @(posedge core_clk_i) ls_tick <= ~ls_tick;
    urx_line_model #(.BIT_CYC(8)) m (.core_clk_i(core_clk_i), .line_o(line0));
    urx_receiver dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
        .low_speed_clock_i(ls_tick), .high_speed_clock_i(1'b1), .serial_rx_input_0_i(line0),
        .serial_rx_input_1_i(1'b1), .port_interrupt_o(irq));
    task automatic chk(input logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Write one register; address and data are released as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk_i);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        bry <= 1'b0;
        chk(br, er);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge core_clk_i);
        ara <= a; arv <= 1'b1; rry <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rry <= 1'b0;
        chk(rd, e);
        chk(rr, er);
    endtask
    // Wait for the one-cycle interrupt pulse; a missing pulse ends in a mismatch
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge core_clk_i);
            n++;
        end
        chk(irq, 1'b1);
    endtask
    // Send a frame, expect the interrupt pulse during the stop bit, then judge buffer and flags
    task automatic frame(input logic [7:0] d, input logic pon, pb, sb, input logic [31:0] st, input logic rb);
        fork
            m.send(d, pon, pb, sb);
            wait_irq();
        join
        if (rb) rdc(URX_OFF_BUF, {24'h0, d}, URX_RESP_OKAY);
        rdc(URX_OFF_STAT, st, URX_RESP_OKAY);
        $display("frame %h done", d);
    endtask
    // Slow source, MSB first, odd parity, two stops; the line carries the word bit-reversed
    task automatic slow_frame;
        rdc(URX_OFF_BUF, 32'h30, URX_RESP_OKAY);
        wr(URX_OFF_STAT, 32'h2, URX_RESP_OKAY);
        wr(URX_OFF_BRL, 3, URX_RESP_OKAY);
        wr(URX_OFF_FMT, 32'h3C, URX_RESP_OKAY);
        wr(URX_OFF_MODE, 32'h1, URX_RESP_OKAY);
        fork
            m.send(8'hBC, 1, 0, 1);
            wait_irq();
        join
        rdc(URX_OFF_BUF, 32'h3D, URX_RESP_OKAY);
        rdc(URX_OFF_STAT, 0, URX_RESP_OKAY);
        $display("slow frame done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog well beyond the expected run of little more than a thousand cycles
    initial begin
        repeat (30000) @(posedge core_clk_i);
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rdc(URX_OFF_STAT, 0, URX_RESP_OKAY);
        rdc(8'h1C, 0, URX_RESP_SLVERR);
        wr(URX_OFF_BUF, 1, URX_RESP_SLVERR);
        wr(URX_OFF_BRL, 7, URX_RESP_OKAY);
        // Receive direction, high-speed source, sampling point shifted one tick
        wr(URX_OFF_MODE, 32'h19, URX_RESP_OKAY);
        wr(URX_OFF_CTRL, 1, URX_RESP_OKAY);
        frame(8'hA5, 0, 0, 1, 0, 1);
        frame(8'h5A, 0, 0, 0, 1, 1);
        // A low stop bit still reads as a start once hunting resumes: a frame of ones with a bad start follows
        wait_irq();
        rdc(URX_OFF_BUF, 32'hFF, URX_RESP_OKAY);
        rdc(URX_OFF_STAT, 1, URX_RESP_OKAY);
        $display("bad stop restart done");
        frame(8'hC3, 0, 0, 1, 0, 1);
        wr(URX_OFF_FMT, 32'h4, URX_RESP_OKAY);
        frame(8'h3D, 1, 0, 1, 4, 1);
        frame(8'h3D, 1, 1, 1, 0, 1);
        frame(8'h11, 1, 0, 1, 0, 0);
        frame(8'h23, 1, 1, 1, 2, 1);
        wr(URX_OFF_STAT, 32'h7, URX_RESP_OKAY);
        frame(8'h30, 1, 0, 1, 0, 0);
        wr(URX_OFF_CTRL, 0, URX_RESP_OKAY);
        wr(URX_OFF_CTRL, 1, URX_RESP_OKAY);
        rdc(URX_OFF_STAT, 2, URX_RESP_OKAY);
        slow_frame();
        complete_run();
    end
endmodule
`default_nettype wire
